// File: include/acvt_defines.vh
`ifndef ACVT_DEFINES_VH
`define ACVT_DEFINES_VH

// register byte offsets
`define ACVT_REG_CTRL     8'h00
`define ACVT_REG_STATUS   8'h04
`define ACVT_REG_MASK     8'h08
`define ACVT_REG_ANGLE    8'h0C
`define ACVT_REG_CTWORD   8'h10

// control fields
`define ACVT_CTRL_TRACK   0
`define ACVT_CTRL_RESET   32'h0000_0001

// status / mask fields
`define ACVT_ST_FAULT     0
`define ACVT_ST_UPDATE    1
`define ACVT_ST_CTXFER    2
`define ACVT_ST_W         3

// resolution select codes {sel_b, sel_a}
`define ACVT_RES_10       2'h0
`define ACVT_RES_12       2'h1
`define ACVT_RES_14       2'h2
`define ACVT_RES_16       2'h3

// tracking error limit in steps of the selected resolution
`define ACVT_ERR_LIMIT    16'h0041

// timing
`define ACVT_CLK_MHZ      50
`define ACVT_STEP_NS      1000
`define ACVT_STEP_CYC     ((`ACVT_STEP_NS * `ACVT_CLK_MHZ) / 1000)
`define ACVT_BUSY_NS      40
`define ACVT_BUSY_CYC     ((`ACVT_BUSY_NS * `ACVT_CLK_MHZ + 999) / 1000)
`define ACVT_OVV_STEPS    8'h40

`endif

// File: hdl/acvt_track.v
`timescale 1ns/1ps
`include "acvt_defines.vh"

module acvt_track
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // control
  input  wire        step_en,
  input  wire        enable,
  input  wire [1:0]  res,
  input  wire [15:0] target,
  input  wire        preset,
  input  wire [15:0] preset_val,
  // state
  output reg  [15:0] angle_q,
  output wire        err_big,
  output wire        over_vel
);

  reg  [7:0]  run_q;
  reg         dir_q;
  wire [15:0] diff = target - angle_q;
  wire        neg = diff[15];
  wire [15:0] mag = neg ? (~diff + 16'h0001) : diff;
  wire [3:0]  shift = 4'h6 - {2'b00, res} - {2'b00, res};
  wire [15:0] lsb = 16'h0001 << shift;
  wire [15:0] err_steps = mag >> shift;
  wire        moving = (err_steps != 16'h0000);

  // error beyond the limit pulls the test flag low
  assign err_big = (err_steps > `ACVT_ERR_LIMIT); // see [R4]
  // slewing at full step rate for too long means the input outruns us
  assign over_vel = (run_q >= `ACVT_OVV_STEPS); // see [R5]

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      angle_q <= 16'h0000;
      run_q   <= 8'h00;
      dir_q   <= 1'b0;
    end
    else if (preset)
    begin
      angle_q <= preset_val;
      run_q   <= 8'h00;
    end
    else if (enable && step_en)
    begin
      // one step of the selected weight, counter aligned to it
      if (moving)
        angle_q <= (neg ? angle_q - lsb : angle_q + lsb) & ~(lsb - 16'h0001);
      if (moving && dir_q == neg && run_q != 8'hFF)
        run_q <= run_q + 8'h01;
      else if (!moving || err_steps <= 16'h0001)
        run_q <= 8'h00;
      else
        run_q <= 8'h01;
      dir_q <= neg;
    end
  end

endmodule // acvt_track

// File: hdl/acvt_port.v
// What this block does
// [R1] lines 9-16 are driven only while the low-byte enable is low
// [R2] lines 1-8 are driven only while the high-byte enable is low
// [R3] hold input low keeps the presented angle word unchanged
// [R4] test flag goes low when tracking error exceeds about 65 steps
// [R5] test flag also goes low when the input outruns the tracker
// [R6] mode pin high tracks; low runs control-transformer comparison
// [R7] two select levels choose 10, 12, 14 or 16 bits, changeable live
// [R8] least valid line is 10/12/14/16; lower lines carry zero
// [R9] line one carries the most significant bit, weights descend
// [R10] busy is high while the parallel word is being updated
// [R11] in transformer mode the sixteen data lines are inputs
// [R12] transformer inputs double buffered: byte latches then whole transfer
// [R13] released lines are not driven; select mapping is a fixed table
`timescale 1ns/1ps
`include "acvt_defines.vh"

module acvt_port
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  // axi4-lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // angle source from the analog front end
  input  wire [15:0] target_angle,
  // data lines, bit 15 is line one
  input  wire [15:0] angle_in,
  output wire [15:0] angle_out,
  output wire [15:0] angle_oe,
  // control pins
  input  wire        high_byte_enable_n,
  input  wire        low_byte_enable_n,
  input  wire        hold_output_n,
  input  wire        track_mode,
  input  wire        res_sel_a,
  input  wire        res_sel_b,
  // status pins
  output reg         conv_busy,
  output reg         test_ok,
  output wire        irq
);

  // pin synchronisers
  reg  [21:0] sync1_q;
  reg  [21:0] sync2_q;
  wire [15:0] din_s    = sync2_q[15:0];
  wire        hi_en_n  = sync2_q[16];
  wire        lo_en_n  = sync2_q[17];
  wire        hold_n   = sync2_q[18];
  wire        track_s  = sync2_q[19];
  wire [1:0]  res_s    = sync2_q[21:20];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= 22'h3F_0000;
      sync2_q <= 22'h3F_0000;
    end
    else
    begin
      sync1_q <= {res_sel_b, res_sel_a, track_mode, hold_output_n,
                  low_byte_enable_n, high_byte_enable_n, angle_in};
      sync2_q <= sync1_q;
    end
  end

  // resolution mask; lines below the selected lsb read zero
  function [15:0] res_mask;
    input [1:0] sel;
    begin
      case (sel)
        `ACVT_RES_10: res_mask = 16'hFFC0;
        `ACVT_RES_12: res_mask = 16'hFFF0;
        `ACVT_RES_14: res_mask = 16'hFFFC;
        default:      res_mask = 16'hFFFF;
      endcase
    end
  endfunction

  // step rate divider; reload is integer wide, cut to the counter on purpose
  reg  [7:0]  div_q;
  wire        step_en = (div_q == 8'h00);
  wire [31:0] step_reload = `ACVT_STEP_CYC - 1;

  always @(posedge aclk)
  begin
    if (!aresetn || step_en)
      div_q <= step_reload[7:0];
    else
      div_q <= div_q - 8'h01;
  end

  // registers
  reg  [31:0] ctrl_q;
  reg  [`ACVT_ST_W-1:0] status_q;
  reg  [`ACVT_ST_W-1:0] mask_q;
  reg  [15:0] upper_q;
  reg  [15:0] ct_word_q;
  reg  [15:0] out_q;
  reg  [1:0]  busy_cnt_q;
  reg  [15:0] snap_q;
  reg         ct_xfer_q;
  reg         fault_q;

  wire [15:0] angle_q;
  wire        err_big;
  wire        over_vel;
  wire        tracking = track_s; // see [R6]

  acvt_track u_track
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .step_en    (step_en),
    .enable     (ctrl_q[`ACVT_CTRL_TRACK] & tracking),
    .res        (res_s), // see [R7]
    .target     (target_angle),
    .preset     (ct_xfer_q),
    .preset_val (ct_word_q),
    .angle_q    (angle_q),
    .err_big    (err_big),
    .over_vel   (over_vel)
  );

  // output word update with busy
  wire [15:0] shown   = angle_q & res_mask(res_s); // see [R8]
  wire        start   = tracking && hold_n && busy_cnt_q == 2'h0
                        && shown != out_q; // see [R3]
  wire        upd_end = busy_cnt_q == 2'h1;
  // busy length fits the two-bit counter; cut on purpose
  wire [31:0] busy_load = `ACVT_BUSY_CYC;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_q      <= 16'h0000;
      snap_q     <= 16'h0000;
      busy_cnt_q <= 2'h0;
      conv_busy  <= 1'b0;
    end
    else
    begin
      if (start)
      begin
        // word snapped at start so an update already begun stays whole
        snap_q     <= shown;
        busy_cnt_q <= busy_load[1:0];
        conv_busy  <= 1'b1; // see [R10]
      end
      else if (busy_cnt_q != 2'h0)
        busy_cnt_q <= busy_cnt_q - 2'h1;
      if (upd_end)
      begin
        out_q     <= snap_q;
        conv_busy <= 1'b0; // see [R10]
      end
    end
  end

  // bit 15 carries line one, the msb
  assign angle_out = out_q; // see [R9]
  // released lines are simply not enabled; the pad floats them
  assign angle_oe[15:8] = {8{tracking & ~hi_en_n}}; // see [R2] [R13]
  assign angle_oe[7:0]  = {8{tracking & ~lo_en_n}}; // see [R1] [R11]

  // transformer mode: byte latches then whole-word transfer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      upper_q   <= 16'h0000;
      ct_word_q <= 16'h0000;
      ct_xfer_q <= 1'b0;
    end
    else
    begin
      ct_xfer_q <= 1'b0;
      if (!tracking)
      begin
        if (!hi_en_n)
          upper_q[15:8] <= din_s[15:8]; // see [R12]
        if (!lo_en_n)
          upper_q[7:0] <= din_s[7:0]; // see [R12]
        if (!hold_n)
        begin
          ct_word_q <= upper_q; // see [R12]
          ct_xfer_q <= 1'b1;
        end
      end
    end
  end

  // test flag, low on fault
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      test_ok <= 1'b1;
      fault_q <= 1'b0;
    end
    else
    begin
      fault_q <= tracking & (err_big | over_vel);
      test_ok <= ~(tracking & (err_big | over_vel)); // see [R4] [R5]
    end
  end

  wire fault_rise = tracking & (err_big | over_vel) & ~fault_q;
  wire [`ACVT_ST_W-1:0] events = {ct_xfer_q, upd_end, fault_rise};

  assign irq = |(status_q & mask_q);

  // axi4-lite write side; address and data taken in either order
  reg        aw_have_q;
  reg        w_have_q;
  reg  [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg  [3:0] w_strb_q;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;

  wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  wire [31:0] mask_wr = merge({{(32-`ACVT_ST_W){1'b0}}, mask_q},
                              w_data_q, w_strb_q);

  // axi4-lite read side
  assign s_axi_arready = !s_axi_rvalid;

  wire rd_take  = s_axi_arvalid && !s_axi_rvalid;
  wire rd_stat  = rd_take && s_axi_araddr == `ACVT_REG_STATUS;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      ctrl_q       <= `ACVT_CTRL_RESET;
      mask_q       <= {`ACVT_ST_W{1'b0}};
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (aw_addr_q)
          `ACVT_REG_CTRL:   ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
          `ACVT_REG_MASK:   mask_q <= mask_wr[`ACVT_ST_W-1:0];
          `ACVT_REG_STATUS: ;
          `ACVT_REG_ANGLE:  ;
          `ACVT_REG_CTWORD: ;
          default:          s_axi_bresp <= 2'h2;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
      status_q     <= {`ACVT_ST_W{1'b0}};
    end
    else
    begin
      // new events win over the clear-on-read
      status_q <= (rd_stat ? {`ACVT_ST_W{1'b0}} : status_q) | events;
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `ACVT_REG_CTRL:   s_axi_rdata <= ctrl_q;
          `ACVT_REG_STATUS: s_axi_rdata <= {{(32-`ACVT_ST_W){1'b0}},
                                            status_q};
          `ACVT_REG_MASK:   s_axi_rdata <= {{(32-`ACVT_ST_W){1'b0}},
                                            mask_q};
          `ACVT_REG_ANGLE:  s_axi_rdata <= {16'h0000, shown};
          `ACVT_REG_CTWORD: s_axi_rdata <= {16'h0000, ct_word_q};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // acvt_port

// File: bench/acvt_port_assertions.sv
`timescale 1ns/1ps

module acvt_port_assertions
(
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // data lines
  input wire [15:0] angle_out,
  input wire [15:0] angle_oe,
  // pins
  input wire        high_byte_enable_n,
  input wire        low_byte_enable_n,
  input wire        hold_output_n,
  input wire        track_mode,
  input wire        res_sel_a,
  input wire        res_sel_b,
  input wire        conv_busy
);
  logic [1:0]  res_q;
  logic [3:0]  res_age_q;
  logic [15:0] inv_mask;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // lsb check only once the select pins have long been still
  always @(posedge aclk)
  begin
    res_q <= {res_sel_b, res_sel_a};
    if (!aresetn || res_q != {res_sel_b, res_sel_a})
      res_age_q <= 4'h0;
    else if (res_age_q != 4'hF)
      res_age_q <= res_age_q + 4'h1;
  end
  assign inv_mask = (16'h0001 << (3'h6 - {res_q, 1'b0})) - 16'h0001;

  property p_low_oe;
    angle_oe[7:0] != 8'h00 |->
      !$past(low_byte_enable_n, 2) && $past(track_mode, 2);
  endproperty
  a_low_oe: assert property (p_low_oe)
    else $error("low byte driven while not enabled");
  property p_high_oe;
    angle_oe[15:8] != 8'h00 |->
      !$past(high_byte_enable_n, 2) && $past(track_mode, 2);
  endproperty
  a_high_oe: assert property (p_high_oe)
    else $error("high byte driven while not enabled");
  property p_oe_whole;
    angle_oe[15:8] inside {8'h00, 8'hFF} && angle_oe[7:0] inside {8'h00, 8'hFF};
  endproperty
  a_oe_whole: assert property (p_oe_whole)
    else $error("byte lines released only in part");
  property p_ct_in;
    !$past(track_mode, 2) |-> angle_oe == 16'h0000;
  endproperty
  a_ct_in: assert property (p_ct_in)
    else $error("data lines driven in transformer mode");
  property p_hold;
    (!hold_output_n) [*6] |=> $stable(angle_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output word moved while held");
  property p_busy_len;
    $rose(conv_busy) |=> conv_busy ##1 !conv_busy;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy pulse not two cycles");
  property p_out_upd;
    $changed(angle_out) |-> $fell(conv_busy);
  endproperty
  a_out_upd: assert property (p_out_upd)
    else $error("output word changed outside busy end");
  property p_lsb;
    $fell(conv_busy) && res_age_q == 4'hF |-> (angle_out & inv_mask) == 16'h0;
  endproperty
  a_lsb: assert property (p_lsb)
    else $error("lines below the lsb not zero");
endmodule // acvt_port_assertions

bind acvt_port acvt_port_assertions i_acvt_port_assertions
(
  .aclk, .aresetn, .angle_out, .angle_oe, .high_byte_enable_n,
  .low_byte_enable_n, .hold_output_n, .track_mode, .res_sel_a,
  .res_sel_b, .conv_busy
);

// File: bench/acvt_host_model.sv
`timescale 1ns/1ps

module acvt_host_model
(
  // clock
  input  wire         aclk,
  // data lines
  input  wire  [15:0] angle_out,
  input  wire  [15:0] angle_oe,
  output logic [15:0] angle_in,
  // control pins
  output logic        high_byte_enable_n = 1'b1,
  output logic        low_byte_enable_n = 1'b1,
  output logic        hold_output_n = 1'b1,
  output logic        track_mode = 1'b1,
  output logic        res_sel_a = 1'b1,
  output logic        res_sel_b = 1'b1
);
  logic [15:0] drv_q = 16'h0000;
  logic        drv_en_q = 1'b0;
  logic [15:0] idle_q = 16'h0000;

  // a floating line must not look like a held value
  always @(posedge aclk) idle_q <= ~idle_q;
  always_comb
    for (int i = 0; i < 16; i++)
      angle_in[i] = angle_oe[i] ? angle_out[i]
                  : drv_en_q ? drv_q[i] : idle_q[i];

  task automatic pins(input logic hi_n, lo_n, hold_n, trk,
                      input logic [1:0] res);
    @(posedge aclk);
    high_byte_enable_n <= hi_n;
    low_byte_enable_n <= lo_n;
    hold_output_n <= hold_n;
    track_mode <= trk;
    {res_sel_b, res_sel_a} <= res;
  endtask

  // host drives lines only while transformer mode is set
  task automatic ct_load(input logic [15:0] hi, input logic [15:0] lo);
    @(posedge aclk);
    drv_en_q <= 1'b1;
    drv_q <= hi;
    repeat (3) @(posedge aclk);
    high_byte_enable_n <= 1'b0;
    repeat (4) @(posedge aclk);
    high_byte_enable_n <= 1'b1;
    repeat (4) @(posedge aclk);
    drv_q <= lo;
    repeat (3) @(posedge aclk);
    low_byte_enable_n <= 1'b0;
    repeat (4) @(posedge aclk);
    low_byte_enable_n <= 1'b1;
    repeat (4) @(posedge aclk);
    drv_q <= ~lo;
    hold_output_n <= 1'b0;
    repeat (4) @(posedge aclk);
    hold_output_n <= 1'b1;
    repeat (4) @(posedge aclk);
    drv_en_q <= 1'b0;
  endtask
endmodule // acvt_host_model

// File: bench/test_angle_converter_digital_port.sv
`timescale 1ns/1ps
`include "acvt_defines.vh"
`define CHK(n, g, e) begin total_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("wrong value %s exp %0h got %0h", n, e, g); end end

module test_angle_converter_digital_port;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [15:0] target_angle = 16'h0000;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [15:0] angle_in, angle_out, angle_oe;
  wire         high_byte_enable_n, low_byte_enable_n, hold_output_n;
  wire         track_mode, res_sel_a, res_sel_b, conv_busy, test_ok, irq;
  int          mismatches = 0, total_checks = 0, cyc = 0;

  acvt_port i_acvt_port
  (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .target_angle, .angle_in, .angle_out, .angle_oe, .high_byte_enable_n,
    .low_byte_enable_n, .hold_output_n, .track_mode, .res_sel_a,
    .res_sel_b, .conv_busy, .test_ok, .irq
  );

  acvt_host_model i_acvt_host_model
  (
    .aclk, .angle_out, .angle_oe, .angle_in, .high_byte_enable_n,
    .low_byte_enable_n, .hold_output_n, .track_mode, .res_sel_a,
    .res_sel_b
  );

  always #10 aclk = ~aclk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w)
    begin
      @(negedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      @(posedge aclk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    `CHK("bresp", s_axi_bresp, r)
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    `CHK("rdata", s_axi_rdata & m, e)
    `CHK("rresp", s_axi_rresp, r)
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic settle(input logic [15:0] e, input int n);
    int k;
    k = 0;
    do @(negedge aclk); while (angle_out !== e && k++ < n);
    `CHK("angle_out", angle_out, e)
  endtask

  task automatic wait_ok(input logic v, input int n);
    int k;
    k = 0;
    do @(negedge aclk); while (test_ok !== v && k++ < n);
    `CHK("test_ok", test_ok, v)
  endtask

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ACVT_REG_CTRL, 32'hFFFFFFFF, 32'h1, 2'h0);
    wr(`ACVT_REG_CTRL, 32'h0, 2'h0);
    rd(`ACVT_REG_CTRL, 32'hFFFFFFFF, 32'h0, 2'h0);
    wr(`ACVT_REG_CTRL, 32'h1, 2'h0);
    rd(`ACVT_REG_MASK, 32'hFFFFFFFF, 32'h0, 2'h0);
    rd(8'h14, 32'hFFFFFFFF, 32'h0, 2'h2);
    wr(8'h14, 32'h1, 2'h2);
    i_acvt_host_model.pins(1'b1, 1'b1, 1'b1, 1'b0, 2'h3);
    i_acvt_host_model.ct_load(16'h5AC3, 16'h3C5A);
    rd(`ACVT_REG_CTWORD, 32'hFFFF, 32'h5A5A, 2'h0);
    rd(`ACVT_REG_STATUS, 32'h4, 32'h4, 2'h0);
    target_angle <= 16'h5A5A;
    i_acvt_host_model.pins(1'b0, 1'b0, 1'b1, 1'b1, 2'h3);
    settle(16'h5A5A, 300);
    `CHK("oe", angle_oe, 16'hFFFF)
    `CHK("line", angle_in[15:8], 8'h5A)
    rd(`ACVT_REG_ANGLE, 32'hFFFF, 32'h5A5A, 2'h0);
    i_acvt_host_model.pins(1'b1, 1'b0, 1'b1, 1'b1, 2'h3);
    settle(16'h5A5A, 4);
    // enables pass two flip-flops before they reach the line drivers
    repeat (2) @(negedge aclk);
    `CHK("oe", angle_oe, 16'h00FF)
    i_acvt_host_model.pins(1'b0, 1'b1, 1'b1, 1'b1, 2'h3);
    settle(16'h5A5A, 4);
    repeat (2) @(negedge aclk);
    `CHK("oe", angle_oe, 16'hFF00)
    for (int r = 3; r >= 0; r--)
    begin
      i_acvt_host_model.pins(1'b0, 1'b0, 1'b1, 1'b1, r[1:0]);
      settle(16'h5A5A & (16'hFFFF << (6 - 2 * r)), 300);
    end
    i_acvt_host_model.pins(1'b0, 1'b0, 1'b0, 1'b1, 2'h0);
    repeat (4) @(posedge aclk);
    target_angle <= 16'h5A9A;
    repeat (150) @(negedge aclk);
    `CHK("held", angle_out, 16'h5A40)
    i_acvt_host_model.pins(1'b0, 1'b0, 1'b1, 1'b1, 2'h0);
    settle(16'h5A80, 300);
    wr(`ACVT_REG_MASK, 32'h1, 2'h0);
    target_angle <= 16'h7A9A;
    wait_ok(1'b0, 300);
    repeat (2) @(negedge aclk);
    `CHK("irq", irq, 1'b1)
    wr(`ACVT_REG_MASK, 32'h0, 2'h0);
    @(negedge aclk);
    `CHK("irq", irq, 1'b0)
    rd(`ACVT_REG_STATUS, 32'h1, 32'h1, 2'h0);
    // error now under the limit, but the slew still outruns the tracker
    repeat (4500) @(negedge aclk);
    `CHK("test_ok", test_ok, 1'b0)
    settle(16'h7A80, 3000);
    wait_ok(1'b1, 300);
    close_out();
  end
endmodule // test_angle_converter_digital_port
